// File: logic/csd_cic.sv
/*
  Cascaded integrator-comb decimator of selectable order.
  Assumes the caller gives one sample strobe per modulator tick and a dump
  strobe at each decimation point.
*/
`default_nettype none

module csd_cic #(
  parameter int ORDER = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic smp_vld_i,
  input wire logic smp_bit_i,
  input wire logic dump_i,
  output logic [csd_pkg::ACC_W-1:0] value_o
);

  typedef struct packed {
    logic [ORDER-1:0][csd_pkg::ACC_W-1:0] integ;
    logic [ORDER-1:0][csd_pkg::ACC_W-1:0] dly;
  } csd_cic_state_t;

  csd_cic_state_t st_r;
  csd_cic_state_t st_nxt;

  // ==========================================================================
  // integrators and combs
  always_comb
  begin
    logic [csd_pkg::ACC_W-1:0] stage;
    logic [csd_pkg::ACC_W-1:0] smp;
    st_nxt = st_r;
    stage = st_r.integ[ORDER-1];
    smp = smp_bit_i ? 64'h0000_0000_0000_0001 : 64'hFFFF_FFFF_FFFF_FFFF;
    for (int k = 0; k < ORDER; k++)
    begin
      if (dump_i)
      begin
        st_nxt.dly[k] = stage;
      end
      stage = stage - st_r.dly[k];
    end
    value_o = stage;
    if (smp_vld_i)
    begin
      st_nxt.integ[0] = st_r.integ[0] + smp;
      for (int k = 1; k < ORDER; k++)
      begin
        st_nxt.integ[k] = st_r.integ[k] + st_r.integ[k-1];
      end
    end
    if (clr_i)
    begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

endmodule : csd_cic

`default_nettype wire

// File: logic/csd_pkg.sv
/*
  Shared constants and types for the clock select and decimation filter block:
  register map, field positions, reset values, clock and decimation figures.
  Assumes the master clock sources arrive as levels sampled on the system clock.
*/
`default_nettype none

package csd_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h01;
  localparam logic [7:0] CHAN_OFS_BASE = 8'h10;
  localparam logic [7:0] FCFG_OFS_BASE = 8'h28;
  localparam int NUM_CH = 4;
  localparam int NUM_SETUP = 4;

  // ==========================================================================
  // reset values
  localparam logic [15:0] MODE_RST = 16'h8000;
  localparam logic [15:0] CHAN0_RST = 16'h8000;
  localparam logic [15:0] CHANX_RST = 16'h0000;
  localparam logic [15:0] FCFG_RST = 16'h0000;

  // ==========================================================================
  // field positions
  localparam int CLKSEL_LSB = 2;
  localparam int CHAN_EN_POS = 15;
  localparam int CHAN_SETUP_LSB = 12;
  localparam int FCFG_MAP_POS = 15;
  localparam int FCFG_TYPE_LSB = 5;
  localparam int FCFG_ODR_LSB = 0;
  localparam int STAT_CHAN_LSB = 0;
  localparam int STAT_FULL_POS = 2;
  localparam int STAT_SETTLE_POS = 3;
  localparam int STAT_SRC_LSB = 4;
  localparam int STAT_VALID_POS = 6;
  localparam int RES_LSB = 24;

  // ==========================================================================
  // clock and decimation figures
  localparam int MCLK_NOM_HZ = 16_000_000;
  localparam int MOD_HZ = MCLK_NOM_HZ / 2;
  localparam int SINC5_ODR_SPS = 10_000;
  localparam int SINC5_DEC = MOD_HZ / SINC5_ODR_SPS;
  localparam int MAP_MULT = 32;
  localparam int SINC3_SETTLE_PERIODS = 3;
  localparam logic [1:0] SINC3_DISCARD = 2'(SINC3_SETTLE_PERIODS - 1);
  localparam logic [9:0] ENH_SINC1_COUNT = 10'd500;
  localparam int CNT_W = 21;
  localparam int ACC_W = 64;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    CSD_SRC_INT_OSC,
    CSD_SRC_INT_OSC_OUT,
    CSD_SRC_EXT_CLK,
    CSD_SRC_CRYSTAL
  } csd_src_t;

  typedef enum logic [1:0] {
    CSD_FT_SINC5_SINC1,
    CSD_FT_ENH_A,
    CSD_FT_ENH_B,
    CSD_FT_SINC3
  } csd_ftype_t;

  typedef struct packed {
    logic [1:0] chan;
    logic [31:0] value;
  } csd_result_t;

  // sinc5 results averaged by sinc1 per output word
  function automatic logic [9:0] odr_count(input logic [4:0] code);
    logic [9:0] n;
    n = ENH_SINC1_COUNT;
    unique case (code)
      5'h00: n = 10'd1;
      5'h01: n = 10'd2;
      5'h02: n = 10'd4;
      5'h03: n = 10'd10;
      5'h04: n = 10'd20;
      5'h05: n = 10'd50;
      5'h06: n = 10'd100;
      5'h07: n = 10'd167;
      5'h08: n = 10'd200;
      default: n = ENH_SINC1_COUNT;
    endcase
    return n;
  endfunction : odr_count

endpackage : csd_pkg

`default_nettype wire

// File: logic/csd_top.sv
/*
  Master clock source selection, modulator clocking and decimation control:
  sinc5+sinc1 and sinc3 paths, per-setup filter config, channel sequencing,
  two-entry output buffer and a plain register port.
  Assumes all inputs are synchronous to REF_CLK_I; clock sources arrive as
  sampled levels and the modulator bit stream on MOD_BIT_I.
*/
// Implementation choices: the address-and-strobe port and the placing of the registers.
// Summary of operation
// - all rates derived from 16 MHz master
// - mode bits 3:2 select clock source
// - reset selects internal oscillator
// - slower master clock scales rates proportionally
// - option drives oscillator out on clock pin
// - external clock mode makes pin input
// - filter types sinc5+sinc1, sinc3, enhanced
// - filter taken from channel's assigned setup
// - sinc5 at 10 kSPS, sinc1 decimates further
// - sinc5+sinc1 settles in one period
// - sinc3 settles in three output periods
// - map bit programs sinc3 decimation directly
// - mapped rate is modulator over 32 times value
// - modulator runs at half master clock
// - mode register 0x01, reset 0x8000
`default_nettype none

module csd_top (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic INT_OSC_I,
  input wire logic CRYSTAL_IN_PIN_I,
  input wire logic CRYSTAL_OUT_CLOCK_IO_PIN_I,
  output logic CRYSTAL_OUT_CLOCK_IO_PIN_O,
  output logic CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O,
  input wire logic MOD_BIT_I,
  output csd_pkg::csd_result_t DATA_O,
  output logic DATA_VALID_O,
  input wire logic DATA_READY_I
);

  typedef struct packed {
    logic [15:0] mode;
    logic [csd_pkg::NUM_CH-1:0][15:0] chan_cfg;
    logic [csd_pkg::NUM_SETUP-1:0][15:0] fcfg;
    logic [15:0] rdata;
    logic src_prev;
    logic mclk_div;
    logic pin_o;
    logic pin_oe_n;
    logic [csd_pkg::CNT_W-1:0] modcnt;
    logic [9:0] s1cnt;
    logic [csd_pkg::ACC_W-1:0] s1acc;
    logic [1:0] res_cnt;
    logic [1:0] chan;
    logic [1:0][33:0] fifo;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] level;
  } csd_state_t;

  csd_state_t st_r;
  csd_state_t st_nxt;
  logic [csd_pkg::ACC_W-1:0] s5_value;
  logic [csd_pkg::ACC_W-1:0] s3_value;
  logic mod_tick;
  logic adv;
  logic s5_dump;
  logic s3_dump;
  logic chan_clr;

  // ==========================================================================
  // helpers
  function automatic logic [csd_pkg::CNT_W-1:0] sinc3_ticks(input logic [15:0] f);
    logic [csd_pkg::CNT_W-1:0] t;
    logic [14:0] n;
    n = (f[14:0] == 15'h0000) ? 15'h0001 : f[14:0];
    // rate = modulator / (32 x value)
    if (f[csd_pkg::FCFG_MAP_POS])
    begin
      t = csd_pkg::CNT_W'(csd_pkg::MAP_MULT) * csd_pkg::CNT_W'(n);
    end
    else
    begin
      t = csd_pkg::CNT_W'(csd_pkg::SINC5_DEC)
        * csd_pkg::CNT_W'(csd_pkg::odr_count(f[csd_pkg::FCFG_ODR_LSB +: 5]));
    end
    return t;
  endfunction : sinc3_ticks

  function automatic logic [1:0] next_chan(input logic [3:0] en, input logic [1:0] cur);
    logic [1:0] n;
    logic found;
    n = cur;
    found = 1'b0;
    for (int k = 1; k <= csd_pkg::NUM_CH; k++)
    begin
      if (!found && en[2'(cur + 2'(k))])
      begin
        n = 2'(cur + 2'(k));
        found = 1'b1;
      end
    end
    return n;
  endfunction : next_chan

  // ==========================================================================
  // filter paths
  csd_cic #(
    .ORDER(5)
  ) u_sinc5 (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .ce_i(CLK_EN_I),
    .clr_i(chan_clr),
    .smp_vld_i(adv),
    .smp_bit_i(MOD_BIT_I),
    .dump_i(s5_dump),
    .value_o(s5_value)
  );

  csd_cic #(
    .ORDER(3)
  ) u_sinc3 (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .ce_i(CLK_EN_I),
    .clr_i(chan_clr),
    .smp_vld_i(adv),
    .smp_bit_i(MOD_BIT_I),
    .dump_i(s3_dump),
    .value_o(s3_value)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [1:0] setup;
    logic [15:0] f;
    logic use_s3;
    logic [9:0] s1_target;
    logic [csd_pkg::CNT_W-1:0] last_tick;
    csd_pkg::csd_src_t src;
    logic src_lvl;
    logic mclk_tick;
    logic period_end;
    logic push;
    logic pop;
    logic [3:0] en;
    logic [1:0] nch;
    logic [csd_pkg::ACC_W-1:0] res;
    st_nxt = st_r;
    src_lvl = 1'b0;
    st_nxt.rdata = 16'h0000;
    push = 1'b0;
    res = '0;
    chan_clr = 1'b0;
    for (int k = 0; k < csd_pkg::NUM_CH; k++)
    begin
      en[k] = st_r.chan_cfg[k][csd_pkg::CHAN_EN_POS];
    end
    // setup assigned to the active channel
    setup = st_r.chan_cfg[st_r.chan][csd_pkg::CHAN_SETUP_LSB +: 2];
    f = st_r.fcfg[setup];
    // map bit forces sinc3, ignores other options
    use_s3 = f[csd_pkg::FCFG_MAP_POS]
      | (f[csd_pkg::FCFG_TYPE_LSB +: 2] == csd_pkg::CSD_FT_SINC3);
    s1_target = (f[csd_pkg::FCFG_TYPE_LSB +: 2] == csd_pkg::CSD_FT_SINC5_SINC1)
      ? csd_pkg::odr_count(f[csd_pkg::FCFG_ODR_LSB +: 5]) : csd_pkg::ENH_SINC1_COUNT;
    last_tick = use_s3 ? sinc3_ticks(f) - 21'h000001
      : csd_pkg::CNT_W'(csd_pkg::SINC5_DEC - 1);
    src = csd_pkg::csd_src_t'(st_r.mode[csd_pkg::CLKSEL_LSB +: 2]);
    unique case (src)
      csd_pkg::CSD_SRC_INT_OSC: src_lvl = INT_OSC_I;
      csd_pkg::CSD_SRC_INT_OSC_OUT: src_lvl = INT_OSC_I;
      csd_pkg::CSD_SRC_EXT_CLK: src_lvl = CRYSTAL_OUT_CLOCK_IO_PIN_I;
      csd_pkg::CSD_SRC_CRYSTAL: src_lvl = CRYSTAL_IN_PIN_I;
    endcase
    // every count runs on modulator ticks, every second master tick
    mclk_tick = src_lvl & ~st_r.src_prev;
    st_nxt.src_prev = src_lvl;
    if (mclk_tick)
    begin
      st_nxt.mclk_div = ~st_r.mclk_div;
    end
    mod_tick = mclk_tick & st_r.mclk_div;
    st_nxt.pin_o = (src == csd_pkg::CSD_SRC_INT_OSC_OUT) & INT_OSC_I;
    st_nxt.pin_oe_n = (src != csd_pkg::CSD_SRC_INT_OSC_OUT);

    // stall conversion while the buffer is full
    adv = mod_tick & (st_r.level != 2'd2) & (en != 4'h0);
    period_end = adv & (st_r.modcnt == last_tick);
    s5_dump = period_end & ~use_s3;
    s3_dump = period_end & use_s3;
    if (adv)
    begin
      st_nxt.modcnt = period_end ? '0 : st_r.modcnt + 21'h000001;
    end

    // one sinc1 period gives settled data
    if (s5_dump)
    begin
      if (st_r.s1cnt >= s1_target - 10'd1)
      begin
        push = 1'b1;
        res = st_r.s1acc + s5_value;
        st_nxt.s1acc = '0;
        st_nxt.s1cnt = 10'd0;
      end
      else
      begin
        st_nxt.s1acc = st_r.s1acc + s5_value;
        st_nxt.s1cnt = st_r.s1cnt + 10'd1;
      end
    end
    // drop results until three periods in
    if (s3_dump)
    begin
      if (st_r.res_cnt < csd_pkg::SINC3_DISCARD)
      begin
        st_nxt.res_cnt = st_r.res_cnt + 2'd1;
      end
      else
      begin
        push = 1'b1;
        res = s3_value;
      end
    end

    // two-entry output buffer
    pop = DATA_READY_I & (st_r.level != 2'd0);
    if (push)
    begin
      st_nxt.fifo[st_r.wr_idx] = {st_r.chan, res[csd_pkg::RES_LSB +: 32]};
      st_nxt.wr_idx = ~st_r.wr_idx;
    end
    if (pop)
    begin
      st_nxt.rd_idx = ~st_r.rd_idx;
    end
    st_nxt.level = st_r.level + 2'(push) - 2'(pop);

    // sequence to the next enabled channel after each word
    nch = next_chan(en, st_r.chan);
    if ((push && nch != st_r.chan) || !en[st_r.chan])
    begin
      st_nxt.chan = nch;
      chan_clr = 1'b1;
      st_nxt.modcnt = '0;
      st_nxt.s1cnt = 10'd0;
      st_nxt.s1acc = '0;
      st_nxt.res_cnt = 2'd0;
    end

    // register port
    if (REG_WR_I)
    begin
      if (REG_ADDR_I == csd_pkg::MODE_OFS)
      begin
        st_nxt.mode = REG_WDATA_I;
      end
      for (int k = 0; k < csd_pkg::NUM_CH; k++)
      begin
        if (REG_ADDR_I == csd_pkg::CHAN_OFS_BASE + 8'(k))
        begin
          st_nxt.chan_cfg[k] = REG_WDATA_I;
        end
        if (REG_ADDR_I == csd_pkg::FCFG_OFS_BASE + 8'(k))
        begin
          st_nxt.fcfg[k] = REG_WDATA_I;
        end
      end
    end
    if (REG_RD_I)
    begin
      if (REG_ADDR_I == csd_pkg::STATUS_OFS)
      begin
        st_nxt.rdata[csd_pkg::STAT_CHAN_LSB +: 2] = st_r.chan;
        st_nxt.rdata[csd_pkg::STAT_FULL_POS] = (st_r.level == 2'd2);
        st_nxt.rdata[csd_pkg::STAT_SETTLE_POS] = use_s3
          & (st_r.res_cnt < csd_pkg::SINC3_DISCARD);
        st_nxt.rdata[csd_pkg::STAT_SRC_LSB +: 2] = src;
        st_nxt.rdata[csd_pkg::STAT_VALID_POS] = (st_r.level != 2'd0);
      end
      if (REG_ADDR_I == csd_pkg::MODE_OFS)
      begin
        st_nxt.rdata = st_r.mode;
      end
      for (int k = 0; k < csd_pkg::NUM_CH; k++)
      begin
        if (REG_ADDR_I == csd_pkg::CHAN_OFS_BASE + 8'(k))
        begin
          st_nxt.rdata = st_r.chan_cfg[k];
        end
        if (REG_ADDR_I == csd_pkg::FCFG_OFS_BASE + 8'(k))
        begin
          st_nxt.rdata = st_r.fcfg[k];
        end
      end
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_r <= '0;
      st_r.mode <= csd_pkg::MODE_RST;
      st_r.chan_cfg <= {csd_pkg::CHANX_RST, csd_pkg::CHANX_RST, csd_pkg::CHANX_RST,
                        csd_pkg::CHAN0_RST};
      st_r.fcfg <= {4{csd_pkg::FCFG_RST}};
      st_r.pin_oe_n <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign REG_RDATA_O = st_r.rdata;
  assign CRYSTAL_OUT_CLOCK_IO_PIN_O = st_r.pin_o;
  assign CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O = st_r.pin_oe_n;
  assign DATA_O = csd_pkg::csd_result_t'(st_r.fifo[st_r.rd_idx]);
  assign DATA_VALID_O = (st_r.level != 2'd0) & CLK_EN_I;

endmodule : csd_top

`default_nettype wire

// File: verif/csd_clk_model.sv
/*
  Clock sources beside the converter: oscillator, crystal, external clock.
  Assumes levels change just after the bench clock edge; rates are scaled.
*/
`default_nettype none

module csd_clk_model (
  input wire logic clk_i,
  input wire logic xtal_run_i,
  output logic int_osc_o,
  output logic crystal_o,
  output logic ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r = 3'h0;
  initial
  begin
    int_osc_o = 1'b0;
    crystal_o = 1'b0;
    ext_clk_o = 1'b0;
  end
  // ==========================================================================
  // level generators, periods 2, 4 and 6 cycles
  always @(posedge clk_i)
  begin
    cnt_r <= (cnt_r == 3'h5) ? 3'h0 : cnt_r + 3'h1;
    int_osc_o <= ~int_osc_o;
    if (xtal_run_i && cnt_r[0])
      crystal_o <= ~crystal_o;
    if (cnt_r == 3'h2 || cnt_r == 3'h5)
      ext_clk_o <= ~ext_clk_o;
  end
endmodule : csd_clk_model

`default_nettype wire

// File: verif/csd_top_sva.sv
/*
  Checker for csd_top: register port, shared clock pin, output buffer.
  Assumes it is bound to csd_top and sees its ports only.
*/
`default_nettype none

module csd_top_sva (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic INT_OSC_I,
  input wire logic CRYSTAL_OUT_CLOCK_IO_PIN_O,
  input wire logic CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O,
  input wire csd_pkg::csd_result_t DATA_O,
  input wire logic DATA_VALID_O,
  input wire logic DATA_READY_I
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // shadow of the mode register
  logic [15:0] mode_r;
  logic [1:0] age_r;
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      mode_r <= csd_pkg::MODE_RST;
      age_r <= 2'h0;
    end
    else if (CLK_EN_I && REG_WR_I && REG_ADDR_I == csd_pkg::MODE_OFS)
    begin
      mode_r <= REG_WDATA_I;
      age_r <= 2'h0;
    end
    else if (CLK_EN_I && age_r != 2'h3)
    begin
      age_r <= age_r + 2'h1;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_rdata_idle_zero: assert property (
    (CLK_EN_I && !REG_RD_I) |=> REG_RDATA_O == 16'h0000)
    else $error("read data not zero outside read answer");
  a_mode_read_back: assert property (
    (REG_RD_I && CLK_EN_I && REG_ADDR_I == csd_pkg::MODE_OFS)
    |=> REG_RDATA_O == $past(mode_r))
    else $error("mode register read back wrong");
  a_unmapped_read: assert property (
    (REG_RD_I && CLK_EN_I && REG_ADDR_I == 8'hFF) ##1 1'b1 |-> REG_RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  a_pin_drive_osc: assert property (
    $past(CLK_EN_I) && !CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O
    |-> CRYSTAL_OUT_CLOCK_IO_PIN_O == $past(INT_OSC_I))
    else $error("pin does not carry oscillator");
  a_pin_quiet_in: assert property (
    CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O |-> !CRYSTAL_OUT_CLOCK_IO_PIN_O)
    else $error("pin drive not low while released");
  a_pin_mode_tie: assert property (
    age_r == 2'h3 |-> CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O == (mode_r[3:2] != 2'h1))
    else $error("pin enable does not follow source code");
  a_reset_quiet: assert property (disable iff (1'b0)
    !RESET_N_I |=> CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O && !DATA_VALID_O && REG_RDATA_O == 16'h0000)
    else $error("outputs not quiet after reset");
  a_data_hold_stall: assert property (
    (CLK_EN_I && DATA_VALID_O && !DATA_READY_I)
    |=> (DATA_VALID_O || !CLK_EN_I) && $stable(DATA_O))
    else $error("stalled word changed or lost");

  c_pin_out: cover property (!CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O);
  c_stall: cover property (DATA_VALID_O && !DATA_READY_I ##1 DATA_VALID_O);
  c_take: cover property (DATA_VALID_O && DATA_READY_I);
endmodule : csd_top_sva

bind csd_top csd_top_sva chk_u (.REF_CLK_I, .RESET_N_I, .CLK_EN_I, .REG_ADDR_I, .REG_WDATA_I,
  .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .INT_OSC_I, .CRYSTAL_OUT_CLOCK_IO_PIN_O,
  .CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O, .DATA_O, .DATA_VALID_O, .DATA_READY_I);

`default_nettype wire

// File: verif/csd_top_test.sv
/*
  Self-checking bench for csd_top: registers, sources, filters, buffer.
  Assumes csd_clk_model for the sources and a random modulator stream.
*/
`default_nettype none

module clock_select_and_decimation_filter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_d = 1'b0;
  logic ready = 1'b1;
  logic mod_bit = 1'b0;
  logic xtal_run = 1'b0;
  logic ce = 1'b1;
  logic [31:0] seed = 32'hCECE;
  logic [15:0] rdata;
  logic int_osc, xtal, ext_clk, pin_o, oe_n, valid;
  csd_pkg::csd_result_t data;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int pop_t[$];
  int cyc = 0;
  int checked = 0;
  int mismatches = 0;
  wire logic pin_lvl = oe_n ? ext_clk : pin_o;

  always #50 clk = ~clk;

  csd_clk_model src_u (.clk_i(clk), .xtal_run_i(xtal_run), .int_osc_o(int_osc),
    .crystal_o(xtal), .ext_clk_o(ext_clk));

  csd_top dut_u (.REF_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(ce), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
    .INT_OSC_I(int_osc), .CRYSTAL_IN_PIN_I(xtal), .CRYSTAL_OUT_CLOCK_IO_PIN_I(pin_lvl),
    .CRYSTAL_OUT_CLOCK_IO_PIN_O(pin_o), .CRYSTAL_OUT_CLOCK_IO_PIN_OE_N_O(oe_n),
    .MOD_BIT_I(mod_bit), .DATA_O(data), .DATA_VALID_O(valid), .DATA_READY_I(ready));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic close_out();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] want, input logic [15:0] m);
    @(posedge clk);
    exp_q.push_back(want);
    msk_q.push_back(m);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd

  // word spacing p cycles; first word after lo and by hi cycles
  task automatic per(input int p, input int lo, input int hi);
    int t0;
    pop_t.delete();
    t0 = cyc;
    repeat (6 * p + 200)
      if (pop_t.size() < 3)
        @(posedge clk);
    chk(pop_t.size() >= 3, 1);
    if (pop_t.size() >= 3)
    begin
      chk(pop_t[2] - pop_t[1], p);
      chk(pop_t[0] - t0 > lo && pop_t[0] - t0 <= hi, 1);
    end
  endtask : per

  // ==========================================================================
  // monitors
  always @(posedge clk)
  begin
    seed <= lfsr(seed);
    mod_bit <= seed[0];
    rd_d <= rd_s;
    cyc <= cyc + 1;
    if (valid === 1'b1 && ready === 1'b1)
    begin
      pop_t.push_back(cyc);
      chk(data.chan, 2'h0);
    end
    if (cyc == 40000)
    begin
      mismatches++;
      close_out();
    end
  end

  always @(negedge clk)
    if (rd_d)
      chk(rdata & msk_q.pop_front(), exp_q.pop_front());

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(csd_pkg::MODE_OFS, 16'h8000, 16'hFFFF);
    rd(csd_pkg::FCFG_OFS_BASE, 16'h0000, 16'hFFFF);
    rd(8'hFF, 16'h0000, 16'hFFFF);
    wr(csd_pkg::FCFG_OFS_BASE, 16'h8002);
    rd(csd_pkg::FCFG_OFS_BASE, 16'h8002, 16'hFFFF);
    per(256, 512, 800);
    xtal_run <= 1'b1;
    wr(csd_pkg::MODE_OFS, 16'h800C);
    rd(csd_pkg::STATUS_OFS, 16'h0030, 16'h0030);
    per(512, 0, 4000);
    wr(csd_pkg::MODE_OFS, 16'h8008);
    per(768, 0, 6000);
    wr(csd_pkg::MODE_OFS, 16'h8004);
    rd(csd_pkg::MODE_OFS, 16'h8004, 16'hFFFF);
    chk(oe_n, 1'b0);
    per(256, 0, 2000);
    ready <= 1'b0;
    repeat (900) @(posedge clk);
    rd(csd_pkg::STATUS_OFS, 16'h0044, 16'h0044);
    // clock enable low: strobe ignored, valid held off
    ce <= 1'b0;
    wr(csd_pkg::MODE_OFS, 16'h800C);
    chk(valid, 1'b0);
    ce <= 1'b1;
    rd(csd_pkg::MODE_OFS, 16'h8004, 16'hFFFF);
    pop_t.delete();
    repeat (40)
      @(posedge clk) ready <= seed[3];
    @(negedge clk);
    chk(pop_t.size(), 2);
    @(posedge clk) ready <= 1'b1;
    wr(csd_pkg::MODE_OFS, 16'h8000);
    wr(csd_pkg::FCFG_OFS_BASE, 16'h0000);
    per(3200, 0, 3232);
    close_out();
  end
endmodule : clock_select_and_decimation_filter_test

`default_nettype wire
